// ---- core/jlu_pkg.sv ----
// Purpose: Shared constants and carriers for the jump-and-link unit.
// Assumes: 32-bit words, 5-bit register indices.
// Notes: Opcode and field positions follow the standard word layout.
package jlu_pkg;

  // ------------------------------------------------------------------
  // Instruction fields
  // ------------------------------------------------------------------
  localparam int OPC_MSB = 31;
  localparam int OPC_LSB = 26;
  localparam int SRC_MSB = 25;
  localparam int SRC_LSB = 21;
  localparam int RT_MSB = 20;
  localparam int RT_LSB = 16;
  localparam int DST_MSB = 15;
  localparam int DST_LSB = 11;
  localparam int HINT_MSB = 10;
  localparam int HINT_LSB = 6;
  localparam int BARRIER_BIT = 10;
  localparam int FUNCT_MSB = 5;
  localparam int INDEX_MSB = 25;
  localparam int REGION_LSB = 28;
  localparam int INDEX_SHIFT = 2;

  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] OPC_REGION_JUMP = 6'h02;
  localparam logic [5:0] OPC_REGION_CALL = 6'h03;
  localparam logic [5:0] FUNCT_INDIRECT_CALL = 6'h09;

  localparam logic [4:0] LINK_REG_DEFAULT = 5'h1F;
  localparam logic [31:0] SLOT_OFFSET = 32'h0000_0004;
  localparam logic [31:0] LINK_OFFSET = 32'h0000_0008;
  localparam logic [3:0] HINT_LOW_DEFAULT = 4'h0;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum {
    JLU_KIND_REGION_JUMP,
    JLU_KIND_REGION_CALL,
    JLU_KIND_INDIRECT_CALL,
    JLU_KIND_INDIRECT_CALL_BARRIER
  } jlu_kind_t;

  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] src_val;
  } jlu_req_t;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [31:0] data;
  } jlu_wr_t;

  typedef struct packed {
    logic valid;
    logic [31:0] target;
    logic isa_sel;
    logic clear_hazards;
  } jlu_redirect_t;

endpackage : jlu_pkg

// ---- core/jlu_target.sv ----
// Purpose: Forms the jump target and next instruction-set select bit.
// Assumes: Inputs are stable in the cycle the jump is issued.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module jlu_target
  import jlu_pkg::*;
#(
  parameter bit COMPRESSED = 1'b0
) (
  input wire logic indirect,
  input wire logic [31:0] pc,
  input wire logic [31:0] instr,
  input wire logic [31:0] src_val,
  input wire logic isa_now,
  output logic [31:0] target,
  output logic isa_next
);
  logic [31:0] slot_pc;

  // Upper bits come from the delay slot, so a jump in the last word lands in the next region
  assign slot_pc = pc + SLOT_OFFSET; // RULE2 RULE18

  always_comb begin
    if (indirect) begin
      target = {src_val[31:1], 1'b0}; // RULE7
      isa_next = COMPRESSED ? src_val[0] : isa_now; // RULE8
    end else begin
      target = {slot_pc[31:REGION_LSB], instr[INDEX_MSB:0], 2'b00}; // RULE1 RULE2
      isa_next = isa_now;
    end
  end
endmodule : jlu_target
`default_nettype wire

// ---- core/jlu_align_chk.sv ----
// Purpose: Decides whether a fetched jump target is misaligned.
// Assumes: raw is the target before bit 0 is forced to zero.
// Notes: Combinational.
`timescale 1ns/10ps
`default_nettype none
module jlu_align_chk #(
  parameter bit COMPRESSED = 1'b0
) (
  input wire logic [31:0] raw,
  output logic misaligned
);
  always_comb begin
    if (COMPRESSED) begin
      misaligned = (raw[0] == 1'b0) && (raw[1] == 1'b1); // RULE10
    end else begin
      misaligned = (raw[1:0] != 2'b00); // RULE9
    end
  end
endmodule : jlu_align_chk
`default_nettype wire

// ---- core/jlu_unit.sv ----
// Purpose: Executes region jumps and register-indirect calls, with delay slot.
// Assumes: Issue, slot-done and fetch-taken strobes come from core logic on clock.
// Notes: One jump in flight; req_ready is low until the target is fetched.
// Notes: COMPRESSED selects the two-set alignment rule and the select-bit load.
// Notes on behaviour
// [RULE1] Region target low 28 bits are the 26-bit index shifted left by two.
// [RULE2] Region target upper bits come from the delay-slot address.
// [RULE3] The instruction after the jump executes before control transfers.
// [RULE4] Region call writes its link into register 31.
// [RULE5] Link value is the jump address plus eight.
// [RULE6] Indirect call writes its link into the destination-field register.
// [RULE7] Indirect target has bit 0 forced to zero.
// [RULE8] With compressed set, select bit loads from source bit 0.
// [RULE9] Without compressed set, nonzero low two bits fault at fetch.
// [RULE10] With compressed set, bit0 zero and bit1 one faults at fetch.
// [RULE11] Software supplies aligned indirect targets without the compact set.
// [RULE12] Only hint zero is defined; other low hint values get default handling.
// [RULE13] Instruction bit 10 selects the hazard-barrier indirect call.
// [RULE14] Barrier form clears hazards before the target is fetched.
// [RULE15] Barrier call is accepted in every mode, no coprocessor check.
// [RULE16] Software keeps source and destination fields different.
// [RULE17] Software puts no jump or return in a delay slot.
// [RULE18] A jump in a region's last word goes to the next region.
// [RULE19] Source value is captured before the link is written.
`timescale 1ns/10ps
`default_nettype none
module jlu_unit
  import jlu_pkg::*;
#(
  parameter bit COMPRESSED = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire jlu_req_t req,
  output logic req_ready,
  output logic req_is_jump,
  input wire logic slot_done,
  input wire logic fetch_taken,
  output jlu_wr_t link_wr,
  output jlu_redirect_t redirect,
  output logic fetch_addr_err,
  output logic isa_sel,
  output logic busy
);

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  logic [5:0] opc;
  logic [5:0] funct;
  logic is_indirect;
  logic is_jump;
  jlu_kind_t kind;

  assign opc = req.instr[OPC_MSB:OPC_LSB];
  assign funct = req.instr[FUNCT_MSB:0];
  assign is_indirect = (opc == OPC_SPECIAL) && (funct == FUNCT_INDIRECT_CALL);
  assign is_jump = is_indirect || (opc == OPC_REGION_JUMP) || (opc == OPC_REGION_CALL);
  assign req_is_jump = is_jump;

  always_comb begin
    if (is_indirect) begin
      // Low hint bits other than zero are reserved and handled as default
      if (req.instr[BARRIER_BIT]) begin // RULE13 RULE12
        kind = JLU_KIND_INDIRECT_CALL_BARRIER;
      end else begin
        kind = JLU_KIND_INDIRECT_CALL;
      end
    end else if (opc == OPC_REGION_CALL) begin
      kind = JLU_KIND_REGION_CALL;
    end else begin
      kind = JLU_KIND_REGION_JUMP;
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_SLOT, ST_FETCH} jlu_state_t;
  jlu_state_t state_r;
  jlu_state_t state_nxt;
  logic take;

  // No mode or coprocessor check gates acceptance, so barrier calls work anywhere
  assign req_ready = (state_r == ST_IDLE); // RULE15
  assign take = req_valid && req_ready && is_jump;
  assign busy = (state_r != ST_IDLE);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_SLOT;
        end
      end
      ST_SLOT: begin
        // Transfer waits for the delay-slot instruction to finish
        if (slot_done) begin // RULE3
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (fetch_taken) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Target capture
  // ------------------------------------------------------------------
  logic [31:0] target_c;
  logic isa_c;
  logic [31:0] target_r;
  logic [31:0] raw_r;
  logic isa_next_r;
  logic barrier_r;
  logic isa_r;
  logic misaligned;
  logic indirect_kind;
  logic barrier_kind;
  logic link_kind;
  logic slot_end;
  logic fetch_end;

  assign indirect_kind = (kind == JLU_KIND_INDIRECT_CALL) || (kind == JLU_KIND_INDIRECT_CALL_BARRIER);
  assign barrier_kind = (kind == JLU_KIND_INDIRECT_CALL_BARRIER); // RULE13
  assign link_kind = (kind != JLU_KIND_REGION_JUMP);
  assign slot_end = (state_r == ST_SLOT) && slot_done; // RULE3
  // A fetch strobe outside the fetch state is ignored
  assign fetch_end = (state_r == ST_FETCH) && fetch_taken;

  // Target and select bit are formed from the request as offered
  jlu_target #(
    .COMPRESSED(COMPRESSED)
  ) u_target (
    .indirect(indirect_kind),
    .pc(req.pc),
    .instr(req.instr),
    .src_val(req.src_val),
    .isa_now(isa_r),
    .target(target_c),
    .isa_next(isa_c)
  );

  // Source value is latched at issue, ahead of the link write that lands a cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_r <= 32'h0000_0000;
    end else if (take) begin
      target_r <= target_c; // RULE19
    end
  end

  // Alignment is judged on the source as given, before bit 0 is cleared
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      raw_r <= 32'h0000_0000;
    end else if (take) begin
      raw_r <= indirect_kind ? req.src_val : target_c; // RULE9 RULE10
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      isa_next_r <= 1'b0;
    end else if (take) begin
      isa_next_r <= isa_c; // RULE8
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      barrier_r <= 1'b0;
    end else if (take) begin
      barrier_r <= barrier_kind; // RULE14
    end
  end

  // ------------------------------------------------------------------
  // Alignment check
  // ------------------------------------------------------------------
  // Region targets are built aligned, so only indirect sources can fault
  jlu_align_chk #(
    .COMPRESSED(COMPRESSED)
  ) u_align (
    .raw(raw_r),
    .misaligned(misaligned)
  );

  // ------------------------------------------------------------------
  // Link write
  // ------------------------------------------------------------------
  logic link_valid_r;
  logic [4:0] link_idx_r;
  logic [31:0] link_data_r;

  // Plain region jumps produce no link write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_valid_r <= 1'b0;
    end else begin
      link_valid_r <= take && link_kind; // RULE4
    end
  end

  // Data and index hold between pulses for a late register-file write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_data_r <= 32'h0000_0000;
    end else if (take) begin
      link_data_r <= req.pc + LINK_OFFSET; // RULE5
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_idx_r <= 5'h00;
    end else if (take && indirect_kind) begin
      link_idx_r <= req.instr[DST_MSB:DST_LSB]; // RULE6
    end else if (take) begin
      link_idx_r <= LINK_REG_DEFAULT; // RULE4
    end
  end

  assign link_wr = '{valid: link_valid_r, idx: link_idx_r, data: link_data_r};

  // ------------------------------------------------------------------
  // Redirect
  // ------------------------------------------------------------------
  logic redir_valid_r;
  logic [31:0] redir_target_r;
  logic redir_clear_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      redir_valid_r <= 1'b0;
    end else begin
      redir_valid_r <= slot_end; // RULE3
    end
  end

  // Target holds after the pulse so fetch may sample it late
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      redir_target_r <= 32'h0000_0000;
    end else if (slot_end) begin
      redir_target_r <= target_r;
    end
  end

  // Clear is raised with the redirect so no target fetch precedes it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      redir_clear_r <= 1'b0;
    end else begin
      redir_clear_r <= slot_end && barrier_r; // RULE14
    end
  end

  assign redirect = '{valid: redir_valid_r, target: redir_target_r,
    isa_sel: isa_r, clear_hazards: redir_clear_r};

  // ------------------------------------------------------------------
  // Select bit and fetch fault
  // ------------------------------------------------------------------
  // Select bit changes with the redirect, never at issue
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      isa_r <= 1'b0;
    end else if (slot_end) begin
      isa_r <= isa_next_r; // RULE8
    end
  end
  assign isa_sel = isa_r;

  // Fault is reported on the fetch of the target, not at issue
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr_err <= 1'b0;
    end else begin
      fetch_addr_err <= fetch_end && misaligned; // RULE9 RULE10
    end
  end

endmodule : jlu_unit
`default_nettype wire

// ---- verification/jlu_unit_properties.sv ----
// Purpose: Port checks for the jump unit.
// Assumes: One jump in flight.
// Notes: Expectations are captured at issue.
`timescale 1ns/10ps
`default_nettype none
module jlu_unit_properties
  import jlu_pkg::*;
#(
  parameter bit COMPRESSED = 1'b0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire jlu_req_t req,
  input wire logic req_ready,
  input wire logic req_is_jump,
  input wire logic slot_done,
  input wire logic fetch_taken,
  input wire jlu_wr_t link_wr,
  input wire jlu_redirect_t redirect,
  input wire logic fetch_addr_err,
  input wire logic isa_sel,
  input wire logic busy
);
  logic take, ind, fst, fst_r, hb_r, err_r, isa_r;
  logic [5:0] opc;
  logic [31:0] sl, tgt_r;
  assign opc = req.instr[OPC_MSB:OPC_LSB];
  assign take = req_valid & req_ready & req_is_jump;
  assign ind = opc == OPC_SPECIAL;
  assign sl = req.pc + SLOT_OFFSET;
  assign fst = redirect.valid | fst_r;
  // Source is changed after issue, so capture here
  always_ff @(posedge clock) begin
    if (take) begin
      tgt_r <= ind ? {req.src_val[31:1], 1'b0} : {sl[31:28], req.instr[25:0], 2'b00};
      hb_r <= ind & req.instr[BARRIER_BIT];
      err_r <= ind & (COMPRESSED ? req.src_val[1:0] == 2'b10 : req.src_val[1:0] != 2'b00);
      isa_r <= (COMPRESSED && ind) ? req.src_val[0] : isa_sel;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fst_r <= 1'b0;
    end else begin
      fst_r <= fst & ~fetch_taken;
    end
  end
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  call_link_a: assert property (take && opc == OPC_REGION_CALL |=> link_wr.valid &&
    link_wr.idx == LINK_REG_DEFAULT && link_wr.data == $past(req.pc) + LINK_OFFSET) else $error("bad call link");
  jump_nolink_a: assert property (take && opc == OPC_REGION_JUMP |=> !link_wr.valid) else $error("jump linked");
  ind_link_a: assert property (take && ind |=> link_wr.valid &&
    link_wr.idx == $past(req.instr[15:11]) && link_wr.data == $past(req.pc) + LINK_OFFSET) else $error("bad link");
  slot_first_a: assert property (redirect.valid |-> $past(slot_done) && !$past(redirect.valid))
    else $error("redirect before slot");
  target_val_a: assert property (redirect.valid |-> redirect.target == tgt_r)
    else $error("bad target");
  barrier_flag_a: assert property (redirect.valid || redirect.clear_hazards |->
    redirect.clear_hazards == (redirect.valid && hb_r)) else $error("bad barrier");
  isa_update_a: assert property (redirect.valid |-> isa_sel == isa_r) else $error("bad select bit");
  addr_err_a: assert property (fst && fetch_taken |=> fetch_addr_err == err_r)
    else $error("bad address error");
  barrier_taken_a: assert property (req_valid && ind && req.instr[5:0] == FUNCT_INDIRECT_CALL |->
    req_is_jump) else $error("call refused");
  cover property (take && !ind);
  issue_busy_a: assert property (take |=> busy && !req_ready) else $error("ready while busy");
  fetch_idle_a: assert property (fst && fetch_taken |=> req_ready && !busy) else $error("not idle after fetch");
  cover property (take && ind && req.instr[BARRIER_BIT]);
  cover property (fetch_addr_err);
endmodule : jlu_unit_properties
bind jlu_unit jlu_unit_properties #(.COMPRESSED(COMPRESSED)) jlu_unit_properties_i (.clock(clock), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .req_is_jump(req_is_jump), .slot_done(slot_done),
  .fetch_taken(fetch_taken), .link_wr(link_wr), .redirect(redirect), .fetch_addr_err(fetch_addr_err),
  .isa_sel(isa_sel), .busy(busy));
`default_nettype wire

// ---- verification/jlu_core_model.sv ----
// Purpose: Core side: ends the delay slot, fetches target.
// Assumes: One jump in flight.
// Notes: Slot ends one cycle after busy rises; fetch follows the redirect by one cycle.
`timescale 1ns/10ps
`default_nettype none
module jlu_core_model
  import jlu_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic busy,
  input wire jlu_redirect_t redirect,
  output logic slot_done,
  output logic fetch_taken
);
  logic done_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_done <= 1'b0;
      done_r <= 1'b0;
    end else begin
      slot_done <= busy & ~done_r & ~slot_done;
      done_r <= busy & (done_r | slot_done);
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_taken <= 1'b0;
    end else begin
      fetch_taken <= redirect.valid;
    end
  end
endmodule : jlu_core_model
`default_nettype wire

// ---- verification/jlu_unit_tb.sv ----
// Purpose: Self-checking bench for the jump unit.
// Assumes: Both set variants see the same jumps.
// Notes: Expected values are formed from the fields.
`timescale 1ns/10ps
`default_nettype none
module jlu_unit_tb
  import jlu_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  jlu_req_t req = '0;
  logic rdy [2], isj [2], sd [2], ft [2], er [2], isa [2], bsy [2];
  jlu_wr_t lw [2];
  jlu_redirect_t rd [2];
  int err_count = 0;
  int cmp_count = 0;
  for (genvar g = 0; g < 2; g++) begin : gu
    jlu_unit #(.COMPRESSED(g == 1)) jlu_unit_i (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
      .req_ready(rdy[g]), .req_is_jump(isj[g]), .slot_done(sd[g]), .fetch_taken(ft[g]), .link_wr(lw[g]),
      .redirect(rd[g]), .fetch_addr_err(er[g]), .isa_sel(isa[g]), .busy(bsy[g]));
    jlu_core_model jlu_core_model_i (.clock(clock), .rst_n(rst_n), .busy(bsy[g]), .redirect(rd[g]),
      .slot_done(sd[g]), .fetch_taken(ft[g]));
  end
  initial begin
    forever #10 clock = ~clock;
  end
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick
  // Source is flipped after issue: target must use the issued value
  task automatic run_jump(input logic [31:0] ins, input logic [31:0] pc, input logic [31:0] src);
    logic ind;
    logic i1;
    logic [1:0] e;
    logic [31:0] sl;
    int n;
    ind = ins[31:26] == OPC_SPECIAL;
    sl = pc + SLOT_OFFSET;
    e = 2'b00;
    n = 0;
    while (rdy[0] !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    i1 = isa[1];
    req = '{ins, pc, src};
    req_valid = 1'b1;
    tick;
    req_valid = 1'b0;
    req.src_val = ~src;
    chk(32'(rdy[0]), 32'h0);
    chk(32'(lw[0].valid), 32'(ins[31:26] != OPC_REGION_JUMP));
    if (lw[0].valid === 1'b1) begin
      chk(32'(lw[0].idx), 32'(ind ? ins[15:11] : LINK_REG_DEFAULT));
      chk(lw[0].data, pc + LINK_OFFSET);
    end
    while (rd[0].valid !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    chk(rd[0].target, ind ? {src[31:1], 1'b0} : {sl[31:28], ins[25:0], 2'b00});
    chk(32'(rd[0].clear_hazards), 32'(ind & ins[BARRIER_BIT]));
    chk(32'(isa[1]), 32'(ind ? src[0] : i1));
    chk(32'(isa[0]), 32'h0);
    while (bsy[0] !== 1'b0 && n < 40) begin
      tick;
      e = e | {er[1], er[0]};
      n++;
    end
    chk(32'(e[0]), 32'(ind && src[1:0] != 2'b00));
    chk(32'(e[1]), 32'(ind && src[1:0] == 2'b10));
    if (n >= 40) begin
      err_count++;
      complete_run();
    end
  endtask : run_jump
  task automatic t_region;
    run_jump({OPC_REGION_JUMP, 26'h3FF_FFFF}, 32'h1234_5670, 32'h0);
    run_jump({OPC_REGION_CALL, 26'h000_0001}, 32'h0FFF_FFFC, 32'h0);
    $display("t_region end");
  endtask : t_region
  task automatic t_indirect;
    run_jump({OPC_SPECIAL, 5'h03, 5'h00, 5'h07, 5'h00, FUNCT_INDIRECT_CALL}, 32'h100, 32'h8000_1001);
    run_jump({OPC_SPECIAL, 5'h04, 5'h00, LINK_REG_DEFAULT, 5'h00, FUNCT_INDIRECT_CALL}, 32'h200, 32'h2000);
    $display("t_indirect end");
  endtask : t_indirect
  task automatic t_barrier;
    run_jump({OPC_SPECIAL, 5'h06, 5'h00, 5'h05, 5'h10, FUNCT_INDIRECT_CALL}, 32'h300, 32'h4002);
    run_jump({OPC_SPECIAL, 5'h06, 5'h00, 5'h05, 5'h03, FUNCT_INDIRECT_CALL}, 32'h400, 32'h4003);
    $display("t_barrier end");
  endtask : t_barrier
  // A non-jump is ignored, and a reset in flight drops the pending jump
  task automatic t_refuse;
    req = '{{OPC_SPECIAL, 20'h00000, 6'h08}, 32'h500, 32'h600};
    req_valid = 1'b1;
    tick;
    req_valid = 1'b0;
    chk(32'(bsy[0]), 32'h0);
    chk(32'(lw[0].valid), 32'h0);
    req = '{{OPC_REGION_CALL, 26'h000_0040}, 32'h600, 32'h0};
    req_valid = 1'b1;
    tick;
    req_valid = 1'b0;
    rst_n = 1'b0;
    tick;
    chk({27'h0, isa[1], bsy[0], lw[0].valid, rd[0].valid, rdy[0]}, 32'h1);
    rst_n = 1'b1;
    run_jump({OPC_REGION_CALL, 26'h000_0040}, 32'h700, 32'h0);
    $display("t_refuse end");
  endtask : t_refuse
  initial begin
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_region;
    t_indirect;
    t_barrier;
    t_refuse;
    complete_run();
  end
endmodule : jlu_unit_tb
`default_nettype wire
